// ===== core/svp_port.sv
// svp_port: serial program/verify command engine with its memories.
// assumes the programmer honours gaps and cycle times; pins arrive raw.
// How it works
// [R01] 6-bit command, optional 16-bit frame, LSb first
// [R02] data bits sampled on clock falling edges
// [R03] programmer leaves gap before data frame
// [R04] low four bits select loads, reads, increment
// [R05] begin-program, bulk erases: no data frame
// [R06] word frame: zero, 14 data, zero
// [R07] byte frame: zero, 8 data, zeros; 16 clocks
// [R08] high-voltage entry: clear pin before supply
// [R09] low-voltage entry: supply, then both pins
// [R10] entry clears counter, holds core in reset
// [R11] load configuration sets counter to 0x2000
// [R12] configuration region sticks until re-entry
// [R13] increment keeps top bit, wraps per region
// [R14] above 0x200F aliases user program memory
// [R15] data memory uses counter low bits
// [R16] program load latches pending 14-bit word
// [R17] begin-program writes pending word, self-timed
// [R18] programmer loads first, waits cycle time
// [R19] programmer bulk-erases before programming series
// [R20] program read from user or configuration
// [R21] drive from second rise, release after sixteenth
// [R22] data read: byte then zero padding
// [R23] programmer loads all ones before erase
// [R24] erase in configuration region clears ids
// [R25] unknown command codes do nothing
`timescale 1ns/10ps
`default_nettype none
`include "svp_regs.svh"
module svp_port (
	// clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_rst,
	// programming pins, asynchronous
	input  wire svp_pkg::svp_pins_t i_pins,
	// data pin drive
	output logic                    o_data_out,
	output logic                    o_data_oe,
	// status
	output logic                    o_mode_active,
	output logic                    o_core_hold,
	output logic                    o_busy
);
	import svp_pkg::*;

	svp_pins_t   pins_s;
	svp_state_t  st_r;
	svp_ld_t     ld_r;
	logic        mode_r;
	logic        clk_d_r;
	logic [13:0] pc_r;
	logic [4:0]  cnt_r;
	logic [4:0]  rcnt_r;
	logic [5:0]  cmd_r;
	logic [15:0] sh_r;
	logic [15:0] rd_r;
	logic [13:0] pend_r;
	logic [3:0]  op_r;
	logic        dout_r;
	logic        oe_r;
	logic        busy_w;
	logic        mode_nxt;
	logic        entry;
	logic        fall;
	logic        rise;
	logic        cmd_done;
	logic        load_done;
	logic [5:0]  code_w;
	logic        tstart;
	logic [11:0] tcyc;

	logic [13:0] prog_mem [0:`SVP_PROG_WORDS-1];
	logic [13:0] cfg_mem  [0:`SVP_CFG_WORDS-1];
	logic [7:0]  data_mem [0:`SVP_DATA_BYTES-1];

	// physical configuration word only at 0x2000..0x200F
	function automatic logic in_cfg(input logic [13:0] a);
		in_cfg = a[13] && (a[12:4] == 9'h000); // [R14]
	endfunction

	svp_sync u_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    (i_pins),
		.o_sync     (pins_s)
	);

	svp_timer u_timer (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_start    (tstart),
		.i_cycles   (tcyc),
		.o_busy     (busy_w)
	);

	assign mode_nxt  = pins_s.hv | (pins_s.master_clear_pin & pins_s.lvep);
	assign entry     = mode_nxt & ~mode_r;
	assign fall      = clk_d_r & ~pins_s.clk; // [R02]
	assign rise      = ~clk_d_r & pins_s.clk;
	assign code_w    = {pins_s.data, cmd_r[5:1]}; // [R01]
	// commands during a self-timed cycle are dropped
	assign cmd_done  = mode_r && (st_r == ST_CMD) && fall
		&& (cnt_r == `SVP_CMD_BITS - 5'd1) && !busy_w;
	assign load_done = mode_r && (st_r == ST_LOAD) && fall
		&& (cnt_r == `SVP_FRAME_BITS - 5'd1);

	// mode detect and link clock edge history
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_r  <= 1'b0;
			clk_d_r <= 1'b0;
		end else begin
			mode_r  <= mode_nxt;
			clk_d_r <= pins_s.clk;
		end
	end

	// serial state, bit counting and shifting
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r  <= ST_CMD;
			cnt_r <= 5'd0;
			cmd_r <= 6'h00;
			sh_r  <= 16'h0000;
			op_r  <= 4'h0;
		end else if (!mode_r) begin
			st_r  <= ST_CMD;
			cnt_r <= 5'd0;
		end else if (fall) begin
			case (st_r)
			ST_CMD: begin
				cmd_r <= code_w;
				if (cnt_r != `SVP_CMD_BITS - 5'd1) begin
					cnt_r <= cnt_r + 5'd1;
				end else begin
					cnt_r <= 5'd0;
					op_r  <= code_w[3:0];
					if (!busy_w) begin
						case (code_w[3:0]) // [R04]
						`SVP_CMD_LD_CFG,
						`SVP_CMD_LD_PROG,
						`SVP_CMD_LD_DATA: st_r <= ST_LOAD;
						`SVP_CMD_RD_PROG,
						`SVP_CMD_RD_DATA: st_r <= ST_READ;
						default:          st_r <= ST_CMD; // [R05] [R25]
						endcase
					end
				end
			end
			// reads shift the line too; sh_r is only used by loads
			ST_LOAD, ST_READ: begin
				sh_r <= {pins_s.data, sh_r[15:1]}; // [R01]
				if (cnt_r == `SVP_FRAME_BITS - 5'd1) begin // [R07]
					cnt_r <= 5'd0;
					st_r  <= ST_CMD;
				end else begin
					cnt_r <= cnt_r + 5'd1;
				end
			end
			default: begin
				st_r  <= ST_CMD;
				cnt_r <= 5'd0;
			end
			endcase
		end
	end

	// address counter
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pc_r <= 14'h0000;
		end else if (entry) begin
			pc_r <= 14'h0000; // [R10]
		end else if (load_done && op_r == `SVP_CMD_LD_CFG) begin
			pc_r <= `SVP_CFG_BASE; // [R11]
		end else if (cmd_done && code_w[3:0] == `SVP_CMD_INC) begin
			if (pc_r[13]) begin
				// top bit held: region cannot be left
				pc_r <= {1'b1, pc_r[12:0] + 13'h0001}; // [R12] [R13]
			end else if (pc_r == `SVP_LAST_USER) begin
				pc_r <= 14'h0000; // [R13]
			end else begin
				pc_r <= pc_r + 14'h0001;
			end
		end
	end

	// pending word from loads
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_r <= `SVP_ERASED_WORD;
			ld_r   <= LD_NONE;
		end else if (entry) begin
			ld_r <= LD_NONE;
		end else if (load_done) begin
			// last frame bit not shifted yet: frame bit k is in sh_r[k+1]
			if (op_r == `SVP_CMD_LD_DATA) begin
				pend_r <= {6'h00, sh_r[9:2]}; // [R07]
				ld_r   <= LD_BYTE;
			end else begin
				pend_r <= sh_r[15:2]; // [R06] [R11] [R16]
				ld_r   <= LD_WORD;
			end
		end else if (cmd_done && code_w[4:0] == `SVP_CMD_BEGIN) begin
			// one write per load
			ld_r <= LD_NONE;
		end
	end

	// self-timed cycle start
	always_comb begin
		tstart = 1'b0;
		tcyc   = 12'h000;
		if (cmd_done) begin
			if (code_w[4:0] == `SVP_CMD_BEGIN && ld_r != LD_NONE) begin
				tstart = 1'b1; // [R17]
				tcyc   = 12'(`SVP_PROG_CYC);
			end else if (code_w[3:0] == `SVP_CMD_ER_PROG
				|| code_w[3:0] == `SVP_CMD_ER_DATA) begin
				tstart = 1'b1;
				tcyc   = 12'(`SVP_ERASE_CYC);
			end
		end
	end

	// memory writes and bulk erases, no reset on storage
	always_ff @(posedge i_core_clk) begin
		if (cmd_done) begin
			if (code_w[4:0] == `SVP_CMD_BEGIN) begin // [R17]
				if (ld_r == LD_BYTE) begin
					data_mem[pc_r[7:0]] <= pend_r[7:0]; // [R15]
				end else if (ld_r == LD_WORD) begin
					if (in_cfg(pc_r)) begin
						cfg_mem[pc_r[3:0]] <= pend_r;
					end else begin
						prog_mem[pc_r[11:0]] <= pend_r; // [R14]
					end
				end
			end else if (code_w[3:0] == `SVP_CMD_ER_PROG) begin
				for (int i = 0; i < `SVP_PROG_WORDS; i++) begin
					prog_mem[i] <= `SVP_ERASED_WORD;
				end
				if (pc_r[13]) begin
					for (int j = 0; j < `SVP_CFG_WORDS; j++) begin
						cfg_mem[j] <= `SVP_ERASED_WORD; // [R24]
					end
				end
			end else if (code_w[3:0] == `SVP_CMD_ER_DATA) begin
				for (int k = 0; k < `SVP_DATA_BYTES; k++) begin
					data_mem[k] <= `SVP_ERASED_BYTE;
				end
			end
		end
	end

	// read frame captured at decode, so a late write cannot tear it
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_r <= 16'h0000;
		end else if (cmd_done) begin
			if (code_w[3:0] == `SVP_CMD_RD_DATA) begin
				rd_r <= {7'h00, data_mem[pc_r[7:0]], 1'b0}; // [R22]
			end else if (in_cfg(pc_r)) begin
				rd_r <= {1'b0, cfg_mem[pc_r[3:0]], 1'b0}; // [R20]
			end else begin
				rd_r <= {1'b0, prog_mem[pc_r[11:0]], 1'b0}; // [R06]
			end
		end
	end

	// data pin drive during read phase
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rcnt_r <= 5'd0;
			dout_r <= 1'b0;
			oe_r   <= 1'b0;
		end else if (!mode_r || st_r != ST_READ) begin
			rcnt_r <= 5'd0;
			dout_r <= 1'b0;
			oe_r   <= 1'b0;
		end else if (rise) begin
			rcnt_r <= rcnt_r + 5'd1;
			if (rcnt_r != 5'd0) begin
				oe_r   <= 1'b1; // [R21]
				dout_r <= rd_r[rcnt_r[3:0]];
			end
		end else if (fall && cnt_r == `SVP_FRAME_BITS - 5'd1) begin
			oe_r <= 1'b0; // [R21]
		end
	end

	assign o_data_out    = dout_r;
	assign o_data_oe     = oe_r;
	assign o_mode_active = mode_r;
	// rest of the chip stays in reset while the port owns the pins
	assign o_core_hold   = mode_r; // [R10]
	assign o_busy        = busy_w;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_oe_read;
		o_data_oe |-> st_r == ST_READ;
	endproperty
	a_oe_read: assert property (p_oe_read) // [R21]
		else $error("data pin driven outside read phase");
	property p_release;
		(st_r == ST_READ && fall && cnt_r == 5'd15) |=> !o_data_oe;
	endproperty
	a_release: assert property (p_release) // [R21]
		else $error("data pin not released after frame");
	property p_entry_zero;
		entry |=> pc_r == 14'h0000;
	endproperty
	a_entry_zero: assert property (p_entry_zero) // [R10]
		else $error("counter not cleared on entry");
	property p_cfg_sticky;
		(mode_r && pc_r[13] && !entry) |=> pc_r[13] || $past(entry, 1);
	endproperty
	a_cfg_sticky: assert property (p_cfg_sticky) // [R12]
		else $error("counter left configuration region");
	property p_ldcfg;
		(load_done && op_r == 4'h0) |=> pc_r == 14'h2000;
	endproperty
	a_ldcfg: assert property (p_ldcfg) // [R11]
		else $error("load configuration did not set 0x2000");
	property p_wrap_cfg;
		(cmd_done && code_w[3:0] == 4'h6 && pc_r == 14'h3FFF)
			|=> pc_r == 14'h2000;
	endproperty
	a_wrap_cfg: assert property (p_wrap_cfg) // [R13]
		else $error("configuration wrap wrong");
	property p_wrap_user;
		(cmd_done && code_w[3:0] == 4'h6 && pc_r == 14'h0FFF)
			|=> pc_r == 14'h0000;
	endproperty
	a_wrap_user: assert property (p_wrap_user) // [R13]
		else $error("user wrap wrong");
	property p_prog_busy;
		(cmd_done && code_w[4:0] == 5'h08 && ld_r != LD_NONE)
			|=> o_busy [*8];
	endproperty
	a_prog_busy: assert property (p_prog_busy) // [R17]
		else $error("program cycle not self-timed");
	property p_fall_only;
		(mode_r && $changed(cmd_r)) |-> $past(fall, 1);
	endproperty
	a_fall_only: assert property (p_fall_only) // [R02]
		else $error("command bit taken off a falling edge");
	property p_noop;
		(cmd_done && code_w[3:0] inside {4'h1, 4'h7, 4'hA, 4'hC,
			4'hD, 4'hE, 4'hF}) |=> $stable(pc_r) && !o_busy;
	endproperty
	a_noop: assert property (p_noop) // [R25]
		else $error("unknown command had an effect");
	property p_no_frame;
		(cmd_done && code_w[3:0] inside {4'h6, 4'h9, 4'hB})
			|=> st_r == ST_CMD;
	endproperty
	a_no_frame: assert property (p_no_frame) // [R05]
		else $error("frameless command entered a data phase");

	c_read: cover property (st_r == ST_READ && o_data_oe);
	c_prog: cover property (cmd_done && code_w[4:0] == 5'h08);
	c_erase: cover property (cmd_done && code_w[3:0] == 4'h9 && pc_r[13]);
	c_cfg: cover property (load_done && op_r == 4'h0);
endmodule
`default_nettype wire

// ===== core/svp_regs.svh
// svp_regs.svh: command codes, address map and timing counts for the
// serial program/verify port; included by the core and the bench.
`ifndef SVP_REGS_SVH
`define SVP_REGS_SVH

// frame lengths
`define SVP_CMD_BITS     5'd6
`define SVP_FRAME_BITS   5'd16
// low four command bits
`define SVP_CMD_LD_CFG   4'h0
`define SVP_CMD_LD_PROG  4'h2
`define SVP_CMD_LD_DATA  4'h3
`define SVP_CMD_INC      4'h6
`define SVP_CMD_RD_PROG  4'h4
`define SVP_CMD_RD_DATA  4'h5
`define SVP_CMD_ER_PROG  4'h9
`define SVP_CMD_ER_DATA  4'hB
// low five command bits
`define SVP_CMD_BEGIN    5'h08
// address map
`define SVP_CFG_BASE     14'h2000
`define SVP_CFG_TOP      14'h3FFF
`define SVP_LAST_USER    14'h0FFF
`define SVP_PROG_WORDS   4096
`define SVP_CFG_WORDS    16
`define SVP_DATA_BYTES   256
`define SVP_ERASED_WORD  14'h3FFF
`define SVP_ERASED_BYTE  8'hFF
// self-timed cycles, core clock 40 MHz
`define SVP_CLK_MHZ      32'd40
`define SVP_PROG_NS      32'd4000
`define SVP_ERASE_NS     32'd6000
`define SVP_PROG_CYC     ((`SVP_PROG_NS * `SVP_CLK_MHZ + 32'd999) / 32'd1000)
`define SVP_ERASE_CYC    ((`SVP_ERASE_NS * `SVP_CLK_MHZ + 32'd999) / 32'd1000)

`endif

// ===== core/svp_pkg.sv
// svp_pkg: types shared by the program/verify port modules.
// assumes svp_regs.svh is on the include path.
package svp_pkg;
	typedef struct packed {
		logic clk;
		logic data;
		logic master_clear_pin;
		logic hv;
		logic lvep;
	} svp_pins_t;

	typedef enum logic [1:0] {
		ST_CMD,
		ST_LOAD,
		ST_READ
	} svp_state_t;

	typedef enum logic [1:0] {
		LD_NONE,
		LD_WORD,
		LD_BYTE
	} svp_ld_t;
endpackage

// ===== core/svp_sync.sv
// svp_sync: two-flop synchroniser for the programming pins.
// assumes pins are asynchronous to i_core_clk.
`timescale 1ns/10ps
`default_nettype none
module svp_sync (
	// clock and reset
	input  wire logic            i_core_clk,
	input  wire logic            i_rst,
	// pins
	input  wire svp_pkg::svp_pins_t i_async,
	output var  svp_pkg::svp_pins_t o_sync
);
	import svp_pkg::*;

	svp_pins_t meta_r;
	svp_pins_t sync_r;

	// meta_r feeds sync_r only
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule
`default_nettype wire

// ===== core/svp_timer.sv
// svp_timer: self-timed write/erase cycle counter.
// assumes i_start is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
`default_nettype none
module svp_timer (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// control
	input  wire logic        i_start,
	input  wire logic [11:0] i_cycles,
	output logic             o_busy
);
	import svp_pkg::*;

	logic [11:0] cnt_r;
	logic        busy_r;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r  <= 12'h000;
			busy_r <= 1'b0;
		end else if (i_start) begin
			cnt_r  <= i_cycles;
			busy_r <= (i_cycles != 12'h000);
		end else if (cnt_r != 12'h000) begin
			cnt_r  <= cnt_r - 12'h001;
			busy_r <= (cnt_r != 12'h001);
		end
	end

	// registered, so the top's busy output comes from a flop
	assign o_busy = busy_r;
endmodule
`default_nettype wire

// ===== testbench/svp_prog_model.sv
// svp_prog_model: behavioural programmer on the clock and data pins.
// assumes callers enter its tasks just after a core clock rise.
`timescale 1ns/10ps
`default_nettype none
module svp_prog_model (
	// clock
	input  wire logic              i_core_clk,
	// device drive of the data line
	input  wire logic              i_data_out,
	input  wire logic              i_data_oe,
	// pins to the device
	output var svp_pkg::svp_pins_t o_pins
);
	import svp_pkg::*;
	logic ck = 1'b0;
	logic en = 1'b1;
	logic dv = 1'b0;
	logic last = 1'b0;
	logic master_clear_pin = 1'b0;
	logic hv = 1'b0;
	logic lvep = 1'b0;
	logic line;
	// no pull on the line: released, it shows the inverse of its last level
	always @(posedge i_core_clk) begin
		if (i_data_oe || en) begin
			last <= line;
		end
	end
	assign line = i_data_oe ? i_data_out : (en ? dv : ~last);
	assign o_pins = '{clk: ck, data: line, master_clear_pin: master_clear_pin, hv: hv, lvep: lvep};
	task automatic wt(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// data set at the rise, held past the fall
	task automatic put(input logic b);
		ck <= 1'b1;
		en <= 1'b1;
		dv <= b;
		wt(4);
		ck <= 1'b0;
		wt(4);
	endtask
	task automatic cmd(input logic [5:0] c);
		for (int i = 0; i < 6; i++)
			put(c[i]);
	endtask
	// idle period before any data frame
	task automatic gap();
		dv <= 1'b0;
		wt(8);
	endtask
	// always sixteen clocks, byte frames too
	task automatic wr(input logic [5:0] c, input logic [15:0] f);
		cmd(c);
		gap();
		for (int i = 0; i < 16; i++)
			put(f[i]);
	endtask
	task automatic rd(input logic [5:0] c, output logic [15:0] f,
		output logic [15:0] oe);
		cmd(c);
		gap();
		en <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			ck <= 1'b1;
			wt(4);
			f[i] = line;
			oe[i] = i_data_oe;
			ck <= 1'b0;
			wt(4);
		end
	endtask
	// clock and data low, clear pin before supply
	task automatic enter_hv();
		ck <= 1'b0;
		en <= 1'b1;
		dv <= 1'b0;
		master_clear_pin <= 1'b1;
		wt(2);
		hv <= 1'b1;
		wt(8);
	endtask
	// supply already up, then clear and entry pins
	task automatic enter_lv();
		en <= 1'b1;
		dv <= 1'b0;
		master_clear_pin <= 1'b1;
		lvep <= 1'b1;
		wt(8);
	endtask
	task automatic leave();
		master_clear_pin <= 1'b0;
		hv <= 1'b0;
		lvep <= 1'b0;
		wt(8);
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: self-checking bench for the program/verify port.
// assumes svp_prog_model plays the programmer on the pins.
`timescale 1ns/10ps
`default_nettype none
`include "svp_regs.svh"
module tb_top;
	import svp_pkg::*;
	logic        i_core_clk;
	logic        i_rst = 1'b1;
	svp_pins_t   pins;
	logic        d_out;
	logic        d_oe;
	logic        mode;
	logic        hold;
	logic        busy;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          pc = int'(`SVP_PROG_CYC) + 10;
	int          ec = int'(`SVP_ERASE_CYC) + 10;
	logic [15:0] f;
	logic [15:0] oe;
	logic [5:0]  bad [8] = '{6'h01, 6'h07, 6'h0A, 6'h0C, 6'h0D, 6'h0E,
		6'h0F, 6'h18};
	svp_port svp_port_i (
		.i_core_clk    (i_core_clk),
		.i_rst         (i_rst),
		.i_pins        (pins),
		.o_data_out    (d_out),
		.o_data_oe     (d_oe),
		.o_mode_active (mode),
		.o_core_hold   (hold),
		.o_busy        (busy)
	);
	svp_prog_model prog_i (
		.i_core_clk (i_core_clk),
		.i_data_out (d_out),
		.i_data_oe  (d_oe),
		.o_pins     (pins)
	);
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard, well above the full run
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic chk(input string w, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask
	// busy must rise at once and end within its bound
	task automatic cyc(input logic [5:0] c, input int lim);
		int n;
		n = 0;
		prog_i.cmd(c);
		prog_i.wt(3);
		chk("busy", 16'h1, {15'h0, busy});
		while (busy === 1'b1 && n < lim) begin
			prog_i.wt(1);
			n++;
		end
		chk("idle", 16'h0, {15'h0, busy});
	endtask
	task automatic rdchk(input logic [5:0] c, input logic [15:0] e);
		prog_i.rd(c, f, oe);
		chk("rd", e, {f[15:1], 1'b0});
		chk("oe", 16'hFFFE, oe);
		prog_i.wt(6);
		chk("rel", 16'h0, {15'h0, d_oe});
	endtask
	task automatic t_entry();
		chk("mode0", 16'h0, {15'h0, mode});
		prog_i.enter_hv();
		chk("mode", 16'h1, {15'h0, mode});
		chk("hold", 16'h1, {15'h0, hold});
		$display("t_entry done");
	endtask
	// erase needs an all-ones load first
	task automatic t_erase();
		prog_i.wr(6'h02, 16'h7FFE);
		cyc(6'h09, ec);
		rdchk(6'h04, 16'h7FFE);
		$display("t_erase done");
	endtask
	task automatic t_prog();
		prog_i.wr(6'h22, {1'b0, 14'h01A5, 1'b0});
		cyc(6'h28, pc);
		for (int i = 0; i < 8; i++) begin
			prog_i.cmd(bad[i]);
			prog_i.wt(4);
			chk("nop", 16'h0, {15'h0, busy});
		end
		rdchk(6'h04, {1'b0, 14'h01A5, 1'b0});
		prog_i.cmd(6'h36);
		rdchk(6'h04, 16'h7FFE);
		$display("t_prog done");
	endtask
	task automatic t_data();
		cyc(6'h0B, ec);
		prog_i.wr(6'h03, {7'h00, 8'h5A, 1'b0});
		cyc(6'h08, pc);
		rdchk(6'h05, {7'h00, 8'h5A, 1'b0});
		cyc(6'h0B, ec);
		rdchk(6'h05, {7'h00, 8'hFF, 1'b0});
		$display("t_data done");
	endtask
	task automatic t_cfg();
		prog_i.wr(6'h00, {1'b0, 14'h0123, 1'b0});
		cyc(6'h08, pc);
		rdchk(6'h04, {1'b0, 14'h0123, 1'b0});
		// sixteen steps leave the physical words and alias user memory
		for (int i = 0; i < 16; i++) begin
			prog_i.cmd(6'h06);
		end
		rdchk(6'h04, 16'h7FFE);
		prog_i.leave();
		prog_i.enter_lv();
		rdchk(6'h04, {1'b0, 14'h01A5, 1'b0});
		prog_i.wr(6'h00, {1'b0, 14'h0ABC, 1'b0});
		prog_i.wr(6'h02, 16'h7FFE);
		cyc(6'h09, ec);
		rdchk(6'h04, 16'h7FFE);
		$display("t_cfg done");
	endtask
	initial begin
		repeat (10) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		t_entry();
		t_erase();
		t_prog();
		t_data();
		t_cfg();
		end_sim();
	end
endmodule
`default_nettype wire
